// ### mic_consts.vh
`ifndef MIC_CONSTS_VH
`define MIC_CONSTS_VH

// register word indices, byte address is four times the index
`define MIC_IDX_MF0      4'h0
`define MIC_IDX_MF5      4'h5
`define MIC_IDX_EDGE     4'h6
`define MIC_IDX_CTRL     4'h7
`define MIC_IDX_GFLAG    4'h8
`define MIC_IDX_STACK    4'h9

// field positions inside each multi-function register
`define MIC_BIT_SER_FLAG 6
`define MIC_BIT_A_FLAG   5
`define MIC_BIT_P_FLAG   4
`define MIC_BIT_SER_EN   2
`define MIC_BIT_A_EN     1
`define MIC_BIT_P_EN     0

// implemented bits, the rest read as zero
`define MIC_MASK_PLAIN   8'h33
`define MIC_MASK_SERIAL  8'h77
// request flag bits of any multi-function register
`define MIC_MASK_FLAGS   8'h70

// control register fields
`define MIC_CTRL_GLOBAL  0
`define MIC_CTRL_EXT_LO  1
`define MIC_CTRL_GRP_LO  3

// edge select codes
`define MIC_EDGE_OFF     2'h0
`define MIC_EDGE_RISE    2'h1
`define MIC_EDGE_FALL    2'h2
`define MIC_EDGE_BOTH    2'h3

// reset values and sizes
`define MIC_RST_BYTE     8'h00
`define MIC_STACK_DEPTH  4'h8
`define MIC_NO_SOURCE    4'h8

`endif

// ### mic_irq_ctrl.v
// Functional notes
// - source events set their request flags regardless of any enable
// - a set flag causes a vector jump only when its enable is one
// - global enable at zero blocks every interrupt
// - taking an interrupt pushes next pc and loads the vector address
// - return from interrupt pops the saved pc for resumption
// - servicing an interrupt clears the global enable automatically
// - requests arriving while blocked still set flags and stay pending
// - no interrupt is acknowledged while the stack is full
// - simultaneous requests are serviced in a fixed priority order
// - any set request flag wakes the device from sleep or idle
// - external pin flag sets on the transition chosen by its edge field
// - pin interrupt needs global enable, pin enable and an active edge
// - servicing a pin interrupt clears its flag and the global enable
// - pull-high selection stays in effect on an interrupt pin
// - each pin triggers on rising, falling or both, or is disabled
// - first register: eeprom flag 5, adc flag 4, enables 1 and 0
// - timer registers: match a flag 5, match p flag 4, enables 1, 0
// - serial registers: serial flag bit 6 and serial enable bit 2
// - unimplemented bits read zero; all flags and enables reset to zero
// - pins have own vectors, other sources share group vectors
// - edge field 00 off, 01 rising, 10 falling, 11 both
// - group flag sets when any enabled source flag in it sets; the code sets it only if no flag in it was already set and enabled
// - group service clears only the group flag, not source flags
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`include "mic_consts.vh"

module mic_irq_ctrl #(
   // priority order: 3-bit source index per slot, slot 0 highest
   parameter [23:0] PRIO_ORDER = 24'hFAC688,
   parameter [15:0] VEC_BASE   = 16'h0004,
   parameter [15:0] VEC_STEP   = 16'h0004
) (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // peripheral event pulses
   input  wire        adc_done_evt,
   input  wire        eeprom_done_evt,
   input  wire [2:0]  ptimer_cmp_a_evt,
   input  wire [2:0]  ptimer_cmp_p_evt,
   input  wire [1:0]  stimer_cmp_a_evt,
   input  wire [1:0]  stimer_cmp_p_evt,
   input  wire [1:0]  serial_evt,
   // external interrupt pins and pull-high
   input  wire [1:0]  ext_irq_pins,
   input  wire [1:0]  pull_high_sel,
   output reg  [1:0]  pull_high_en,
   // cpu core side
   input  wire        cpu_boundary,
   input  wire [15:0] cpu_next_pc,
   input  wire        cpu_call,
   input  wire        cpu_ret,
   input  wire        return_from_irq_instr,
   output reg         pc_load,
   output reg  [15:0] pc_load_value,
   output reg         irq_taken,
   output reg  [2:0]  irq_source,
   output reg         stack_full,
   output reg         wake_up
);

   ////////////////////////////////////////////////////////////////////////////
   // helper functions

   // enabled pending state of one multi-function register
   function mf_pending;
      input [7:0] r;
      begin
         mf_pending = (r[`MIC_BIT_A_FLAG] & r[`MIC_BIT_A_EN]) |
                      (r[`MIC_BIT_P_FLAG] & r[`MIC_BIT_P_EN]) |
                      (r[`MIC_BIT_SER_FLAG] & r[`MIC_BIT_SER_EN]);
      end
   endfunction

   // decode of a two-bit edge field
   function edge_hit;
      input [1:0] sel;
      input       rise;
      input       fall;
      begin
         case (sel)
            `MIC_EDGE_RISE: edge_hit = rise;
            `MIC_EDGE_FALL: edge_hit = fall;
            `MIC_EDGE_BOTH: edge_hit = rise | fall;
            default:        edge_hit = 1'b0;
         endcase
      end
   endfunction

   // fixed priority pick, lowest slot wins because it is written last
   function [3:0] prio_pick;
      input [7:0]  req;
      input [23:0] ord;
      integer      k;
      reg   [2:0]  s;
      begin
         prio_pick = `MIC_NO_SOURCE;
         s = 3'h0;
         for (k = 7; k >= 0; k = k - 1) begin
            s = ord[3*k +: 3];
            if (req[s]) begin
               prio_pick = {1'b0, s};
            end
         end
      end
   endfunction

   // implemented-bit mask; serial bits only in registers 3 and 4
   function [7:0] mf_mask;
      input [2:0] n;
      begin
         if (n == 3'h3 || n == 3'h4) begin
            mf_mask = `MIC_MASK_SERIAL;
         end else begin
            mf_mask = `MIC_MASK_PLAIN;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state

   reg  [7:0]  mf_reg [0:5];
   reg  [3:0]  edge_sel_reg;
   reg         global_irq_enable_reg;
   reg  [1:0]  ext_pin_irq_enables_reg;
   reg  [5:0]  group_irq_enable_reg;
   reg  [1:0]  ext_pin_irq_flags_reg;
   reg  [5:0]  group_irq_flag_reg;
   reg  [5:0]  group_term_reg;
   reg  [1:0]  pin_prev_reg;
   reg         pin_prev_ok_reg;
   reg  [15:0] stack_mem [0:7];
   reg  [3:0]  sp_reg;
   // separate loop indices keep each variable to one process
   integer     i;
   integer     j;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode

   wire [3:0]  idx      = paddr[5:2];
   wire        mapped   = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) &&
                          (idx <= `MIC_IDX_STACK);
   wire        setup    = psel & ~penable;
   // accesses to unmapped words never write anything
   wire        access   = psel & penable & pready & ~pslverr;
   wire        apb_wr   = access & pwrite;
   wire        wr_ctrl  = apb_wr && (idx == `MIC_IDX_CTRL);
   wire        wr_gflag = apb_wr && (idx == `MIC_IDX_GFLAG);
   wire        wr_edge  = apb_wr && (idx == `MIC_IDX_EDGE);

   ////////////////////////////////////////////////////////////////////////////
   // event mapping onto register bits

   wire [47:0] mf_set = {
      8'h00 | ({7'h00, ptimer_cmp_a_evt[2]} << `MIC_BIT_A_FLAG)
            | ({7'h00, ptimer_cmp_p_evt[2]} << `MIC_BIT_P_FLAG),
      8'h00 | ({7'h00, serial_evt[1]} << `MIC_BIT_SER_FLAG)
            | ({7'h00, ptimer_cmp_a_evt[1]} << `MIC_BIT_A_FLAG)
            | ({7'h00, ptimer_cmp_p_evt[1]} << `MIC_BIT_P_FLAG),
      8'h00 | ({7'h00, serial_evt[0]} << `MIC_BIT_SER_FLAG)
            | ({7'h00, stimer_cmp_a_evt[1]} << `MIC_BIT_A_FLAG)
            | ({7'h00, stimer_cmp_p_evt[1]} << `MIC_BIT_P_FLAG),
      8'h00 | ({7'h00, stimer_cmp_a_evt[0]} << `MIC_BIT_A_FLAG)
            | ({7'h00, stimer_cmp_p_evt[0]} << `MIC_BIT_P_FLAG),
      8'h00 | ({7'h00, ptimer_cmp_a_evt[0]} << `MIC_BIT_A_FLAG)
            | ({7'h00, ptimer_cmp_p_evt[0]} << `MIC_BIT_P_FLAG),
      8'h00 | ({7'h00, eeprom_done_evt} << `MIC_BIT_A_FLAG)
            | ({7'h00, adc_done_evt} << `MIC_BIT_P_FLAG)
   };

   ////////////////////////////////////////////////////////////////////////////
   // request evaluation

   reg  [5:0]  group_term;
   reg  [1:0]  pin_edge;
   always @* begin
      for (j = 0; j < 6; j = j + 1) begin
         group_term[j] = mf_pending(mf_reg[j]);
      end
      // a pin edge is only seen after one settled sample
      // trade-off: the settling sample costs a cycle after reset but
      // keeps the reset value of the previous sample from faking an edge
      for (j = 0; j < 2; j = j + 1) begin
         pin_edge[j] = pin_prev_ok_reg &
                       edge_hit(edge_sel_reg[2*j +: 2],
                                ext_irq_pins[j] & ~pin_prev_reg[j],
                                ~ext_irq_pins[j] & pin_prev_reg[j]);
      end
   end

   // group flag sets when the group goes from no enabled source request to one
   // a level would raise the group again right after service; an edge does not
   wire [5:0]  group_set = group_term & ~group_term_reg;

   // pin request also needs a non-disabled edge field
   wire [1:0]  edge_active = {|edge_sel_reg[3:2], |edge_sel_reg[1:0]};
   wire [1:0]  ext_req = ext_pin_irq_flags_reg & ext_pin_irq_enables_reg &
                         edge_active;
   // group requests gated by their group enables
   wire [7:0]  req_all = {group_irq_flag_reg & group_irq_enable_reg, ext_req};
   wire [3:0]  winner  = prio_pick(req_all, PRIO_ORDER);

   // global enable, room on the stack, and a clean boundary
   // no take while pc_load stands, so entries are two cycles apart
   wire        take = global_irq_enable_reg & ~sp_reg[3] & cpu_boundary &
                      ~pc_load & ~winner[3];
   // evenly spaced vectors; base and step are parameters
   wire [15:0] vec  = VEC_BASE + ({13'h0000, winner[2:0]} * VEC_STEP);

   // pins have slots 0 and 1, groups slots 2 to 7
   wire [1:0]  ext_clr   = take ? (2'h1 << winner[0]) & {2{~|winner[2:1]}} : 2'h0;
   wire [7:0]  grp_onehot = 8'h01 << winner[2:0];
   wire [5:0]  grp_clr   = take ? grp_onehot[7:2] : 6'h00;

   // an entry owns the stack in its cycle; a call or pop then is lost
   wire        do_pop  = (cpu_ret | return_from_irq_instr) & (sp_reg != 4'h0) & ~take;
   wire        do_call = cpu_call & ~sp_reg[3] & ~take;

   ////////////////////////////////////////////////////////////////////////////
   // read mux

   reg  [31:0] rd_data;
   // unimplemented bits are never stored, so no read mask is needed
   always @* begin
      rd_data = 32'h0000_0000;
      if (idx <= `MIC_IDX_MF5) begin
         rd_data[7:0] = mf_reg[idx[2:0]];
      end else if (idx == `MIC_IDX_EDGE) begin
         rd_data[3:0] = edge_sel_reg;
      end else if (idx == `MIC_IDX_CTRL) begin
         rd_data[8:0] = {group_irq_enable_reg, ext_pin_irq_enables_reg,
                         global_irq_enable_reg};
      end else if (idx == `MIC_IDX_GFLAG) begin
         rd_data[7:0] = {group_irq_flag_reg, ext_pin_irq_flags_reg};
      end else if (idx == `MIC_IDX_STACK) begin
         rd_data[3:0] = sp_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb response, one access cycle with no extra wait
   // a refused transfer still gets its ready, so the master never stalls

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         if (setup) begin
            prdata <= mapped ? rd_data : 32'h0000_0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flags and enables

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (i = 0; i < 6; i = i + 1) begin
            mf_reg[i] <= `MIC_RST_BYTE;
         end
         edge_sel_reg            <= 4'h0;
         global_irq_enable_reg   <= 1'b0;
         ext_pin_irq_enables_reg <= 2'h0;
         group_irq_enable_reg    <= 6'h00;
         ext_pin_irq_flags_reg   <= 2'h0;
         group_irq_flag_reg      <= 6'h00;
         group_term_reg          <= 6'h00;
         pin_prev_reg            <= 2'h0;
         pin_prev_ok_reg         <= 1'b0;
      end else begin
         // events set flags whatever the enables; set beats clear
         for (i = 0; i < 6; i = i + 1) begin
            mf_reg[i] <= (((apb_wr && idx == i) ? pwdata[7:0] : mf_reg[i]) |
                          mf_set[8*i +: 8]) & mf_mask(i[2:0]);
         end
         if (wr_edge) begin
            edge_sel_reg <= pwdata[3:0];
         end
         // servicing drops the global enable, over a software write
         if (take) begin
            global_irq_enable_reg <= 1'b0;
         end else if (wr_ctrl) begin
            global_irq_enable_reg <= pwdata[`MIC_CTRL_GLOBAL];
         end
         if (wr_ctrl) begin
            ext_pin_irq_enables_reg <= pwdata[`MIC_CTRL_EXT_LO +: 2];
            group_irq_enable_reg    <= pwdata[`MIC_CTRL_GRP_LO +: 6];
         end
         // pin flags: edge sets, service clears, set wins
         ext_pin_irq_flags_reg <= ((wr_gflag ? pwdata[1:0] : ext_pin_irq_flags_reg)
                                   & ~ext_clr) | pin_edge;
         // group flag alone is cleared by service
         group_irq_flag_reg <= ((wr_gflag ? pwdata[7:2] : group_irq_flag_reg)
                                & ~grp_clr) | group_set;
         group_term_reg  <= group_term;
         pin_prev_reg    <= ext_irq_pins;
         pin_prev_ok_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // return stack; array has no reset since sp guards every read

   always @(posedge pclk) begin
      // push the next pc on entry or on a call
      if (take || do_call) begin
         stack_mem[sp_reg[2:0]] <= cpu_next_pc;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_reg        <= 4'h0;
         pc_load       <= 1'b0;
         pc_load_value <= 16'h0000;
         irq_taken     <= 1'b0;
         irq_source    <= 3'h0;
         stack_full    <= 1'b0;
         wake_up       <= 1'b0;
         pull_high_en  <= 2'h0;
      end else begin
         // pointer runs 0 to 8; bit 3 alone marks a full stack
         // full stack stops entries until a pop frees a level
         if (take || do_call) begin
            sp_reg <= sp_reg + 4'h1;
         end else if (do_pop) begin
            sp_reg <= sp_reg - 4'h1;
         end
         stack_full <= (take || do_call) ? (sp_reg == `MIC_STACK_DEPTH - 4'h1) :
                       do_pop ? 1'b0 : sp_reg[3];
         pc_load   <= take | do_pop;
         irq_taken <= take;
         if (take) begin
            pc_load_value <= vec;
            irq_source    <= winner[2:0];
         end else if (do_pop) begin
            pc_load_value <= stack_mem[sp_reg[2:0] - 3'h1];
         end
         // any set flag requests a wake-up
         // enable bits masked off: a set enable alone must not wake the core
         wake_up <= (|{group_irq_flag_reg, ext_pin_irq_flags_reg}) |
                    (|((mf_reg[0] | mf_reg[1] | mf_reg[2] | mf_reg[3] |
                        mf_reg[4] | mf_reg[5]) & `MIC_MASK_FLAGS));
         pull_high_en <= pull_high_sel;
      end
   end

endmodule

// ### mic_irq_ctrl_assertions.sv
`timescale 1ns/10ps
module mic_irq_ctrl_chk #(
   parameter [23:0] PRIO_ORDER = 24'hFAC688,
   parameter [15:0] VEC_BASE   = 16'h0004,
   parameter [15:0] VEC_STEP   = 16'h0004
) (
   // clock and reset
   input wire        pclk,
   input wire        presetn,
   // register bus
   input wire        psel,
   input wire        penable,
   input wire        pready,
   input wire        pslverr,
   // sources and pins
   input wire        adc_done_evt,
   input wire [1:0]  pull_high_sel,
   input wire [1:0]  pull_high_en,
   // core side
   input wire        cpu_ret,
   input wire        return_from_irq_instr,
   input wire        pc_load,
   input wire [15:0] pc_load_value,
   input wire        irq_taken,
   input wire [2:0]  irq_source,
   input wire        stack_full,
   input wire        wake_up
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // steps of a bus transfer and of an entry
   sequence s_setup; psel && !penable; endsequence
   sequence s_entry; irq_taken && pc_load; endsequence
   sequence s_quiet; !irq_taken [*2]; endsequence
   property p_ready; s_setup |=> pready; endproperty
   property p_err; pslverr |-> pready; endproperty
   property p_taken; irq_taken |-> pc_load; endproperty
   property p_vector; s_entry |-> pc_load_value == VEC_BASE + VEC_STEP * {13'h0, irq_source};
   endproperty
   // global enable drops on entry, so no second entry can follow at once
   property p_no_nest; s_entry |=> s_quiet; endproperty
   property p_full; stack_full |=> !irq_taken; endproperty
   property p_wake; adc_done_evt |-> ##2 wake_up; endproperty
   property p_pull; $past(presetn) |-> pull_high_en == $past(pull_high_sel); endproperty
   property p_pop; pc_load && !irq_taken |-> $past(cpu_ret) || $past(return_from_irq_instr);
   endproperty
   a_ready: assert property (p_ready) else $error("no ready in access cycle");
   a_err: assert property (p_err) else $error("error without ready");
   a_taken: assert property (p_taken) else $error("entry without pc load");
   a_vector: assert property (p_vector) else $error("wrong vector");
   a_no_nest: assert property (p_no_nest) else $error("nested entry");
   a_full: assert property (p_full) else $error("entry with full stack");
   a_wake: assert property (p_wake) else $error("no wake after event");
   a_pull: assert property (p_pull) else $error("pull-high lost");
   a_pop: assert property (p_pop) else $error("pc load without cause");
endmodule
bind mic_irq_ctrl mic_irq_ctrl_chk #(.PRIO_ORDER(PRIO_ORDER), .VEC_BASE(VEC_BASE),
   .VEC_STEP(VEC_STEP)) u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .adc_done_evt, .pull_high_sel, .pull_high_en, .cpu_ret, .return_from_irq_instr,
   .pc_load, .pc_load_value, .irq_taken, .irq_source, .stack_full, .wake_up);

// ### mic_core_model.sv
`timescale 1ns/10ps
module mic_core_model (
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // bench commands
   input  wire        slow,
   input  wire        call_req,
   input  wire [1:0]  pop_req,
   // controller side
   input  wire        pc_load,
   input  wire [15:0] pc_load_value,
   output reg         cpu_boundary,
   output reg  [15:0] cpu_next_pc,
   output wire        cpu_call,
   output wire        cpu_ret,
   output wire        return_from_irq_instr
);
   // pc follows every load, else steps; a slow core offers every other boundary
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_next_pc  <= 16'h0100;
         cpu_boundary <= 1'h0;
      end else begin
         cpu_next_pc  <= pc_load ? pc_load_value : cpu_next_pc + 16'h0001;
         cpu_boundary <= slow ? ~cpu_boundary : 1'h1;
      end
   end
   assign return_from_irq_instr = pop_req[0];
   assign cpu_ret               = pop_req[1];
   assign cpu_call              = call_req;
endmodule

// ### test_mcu_interrupt_controller.sv
`timescale 1ns/10ps
module test_mcu_interrupt_controller;
   localparam [15:0] VB = 16'h0010;
   localparam [15:0] VS = 16'h0008;
   // design pins
   logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rdat, rerr, src, vec, sav, sav0;
   wire  [31:0] prdata;
   wire         pready, pslverr, pc_load, irq_taken, stack_full, wake_up;
   wire         cpu_boundary, cpu_call, cpu_ret, return_from_irq_instr;
   wire  [15:0] cpu_next_pc, pc_load_value;
   wire  [2:0]  irq_source;
   wire  [1:0]  pull_high_en;
   logic        adc_done_evt = 1'h0, eeprom_done_evt = 1'h0, slow = 1'h0, call_req = 1'h0;
   logic [2:0]  ptimer_cmp_a_evt = 3'h0, ptimer_cmp_p_evt = 3'h0;
   logic [1:0]  stimer_cmp_a_evt = 2'h0, stimer_cmp_p_evt = 2'h0, serial_evt = 2'h0;
   logic [1:0]  ext_irq_pins = 2'h0, pull_high_sel = 2'h2, pop_req = 2'h0;
   logic [15:0] prev_pc;
   integer      err_total = 0, n_checks = 0, i;
   // clock, and the address the core offered one cycle back
   always #4 pclk = ~pclk;
   always @(posedge pclk) prev_pc <= cpu_next_pc;
   mic_irq_ctrl #(.VEC_BASE(VB), .VEC_STEP(VS)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .adc_done_evt, .eeprom_done_evt,
      .ptimer_cmp_a_evt, .ptimer_cmp_p_evt, .stimer_cmp_a_evt, .stimer_cmp_p_evt, .serial_evt,
      .ext_irq_pins, .pull_high_sel, .pull_high_en, .cpu_boundary, .cpu_next_pc, .cpu_call,
      .cpu_ret, .return_from_irq_instr, .pc_load, .pc_load_value, .irq_taken, .irq_source,
      .stack_full, .wake_up);
   mic_core_model u_core (.pclk, .presetn, .slow, .call_req, .pop_req, .pc_load,
      .pc_load_value, .cpu_boundary, .cpu_next_pc, .cpu_call, .cpu_ret, .return_from_irq_instr);
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input [31:0] got, input [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // one bus transfer, held until pready is sampled high, bounded
   task xfer(input w, input [3:0] idx, input [31:0] d);
      integer n;
      logic   hit;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'h1 && n < 16);
      hit = (pready === 1'h1);
      rdat = prdata;
      rerr = {31'h0, pslverr};
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
      if (!hit) begin err_total++; close_out; end
   endtask
   task rd(input [3:0] idx, input [31:0] exp);
      xfer(1'h0, idx, 32'h0);
      chk(rdat, exp);
   endtask
   // watch a fixed window for an entry; FF means none
   task wt(input [31:0] exp);
      integer n;
      src = 32'hFF;
      for (n = 0; n < 16 && src == 32'hFF; n++) begin
         @(posedge pclk);
         if (irq_taken === 1'h1) begin
            src = {29'h0, irq_source};
            vec = {16'h0, pc_load_value};
            sav = {16'h0, prev_pc};
         end
      end
      chk(src, exp);
   endtask
   // single-cycle pop, then the restored address
   task pop(input [1:0] kind, input [31:0] exp);
      integer n;
      pop_req <= kind;
      @(posedge pclk);
      pop_req <= 2'h0;
      for (n = 0; n < 8 && pc_load !== 1'h1; n++) @(posedge pclk);
      // a missing load is a timeout and ends the run
      if (pc_load !== 1'h1) begin
         err_total++;
         close_out;
      end else begin
         chk({16'h0, pc_load_value}, exp);
      end
   endtask
   task pulse;
      {adc_done_evt, eeprom_done_evt, ptimer_cmp_a_evt, ptimer_cmp_p_evt,
         stimer_cmp_a_evt, stimer_cmp_p_evt, serial_evt} <= 14'h3FFF;
      @(posedge pclk);
      {adc_done_evt, eeprom_done_evt, ptimer_cmp_a_evt, ptimer_cmp_p_evt,
         stimer_cmp_a_evt, stimer_cmp_p_evt, serial_evt} <= 14'h0;
      @(posedge pclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      // reset values and implemented bits of each group register
      for (i = 0; i < 6; i++) begin
         rd(i[3:0], 32'h0);
         xfer(1'h1, i[3:0], 32'hFFFF_FFFF);
         rd(i[3:0], (i == 3 || i == 4) ? 32'h77 : 32'h33);
         xfer(1'h1, i[3:0], 32'h0);
      end
      rd(4'h9, 32'h0);
      rd(4'hA, 32'h0);
      chk(rerr, 32'h1);
      chk({30'h0, pull_high_en}, 32'h2);
      $display("registers done");
      // every peripheral source fires with source enables off: flags only, no entry
      xfer(1'h1, 4'h8, 32'h0);
      xfer(1'h1, 4'h7, 32'h1F9);
      pulse;
      wt(32'hFF);
      chk({31'h0, wake_up}, 32'h1);
      for (i = 0; i < 6; i++) begin
         rd(i[3:0], (i == 3 || i == 4) ? 32'h70 : 32'h30);
         xfer(1'h1, i[3:0], 32'h0);
      end
      $display("events done");
      // conversion done while blocked, served once global enable is set
      xfer(1'h1, 4'h8, 32'h0);
      xfer(1'h1, 4'h0, 32'h1);
      xfer(1'h1, 4'h7, 32'h8);
      chk({31'h0, wake_up}, 32'h0);
      pulse;
      wt(32'hFF);
      rd(4'h8, 32'h4);
      slow <= 1'h1;
      xfer(1'h1, 4'h7, 32'h9);
      wt(32'h2);
      chk(vec, {16'h0, VB + 16'h0002 * VS});
      rd(4'h7, 32'h8);
      rd(4'h8, 32'h0);
      rd(4'h0, 32'h31);
      rd(4'h9, 32'h1);
      slow <= 1'h0;
      pop(2'h1, sav);
      rd(4'h9, 32'h0);
      xfer(1'h1, 4'h0, 32'h0);
      $display("group entry done");
      // each edge code against a rise and then a fall on pin 0
      for (i = 0; i < 4; i++) begin
         xfer(1'h1, 4'h6, i);
         xfer(1'h1, 4'h8, 32'h0);
         ext_irq_pins <= 2'h1;
         repeat (3) @(posedge pclk);
         rd(4'h8, i & 1);
         xfer(1'h1, 4'h8, 32'h0);
         ext_irq_pins <= 2'h0;
         repeat (3) @(posedge pclk);
         rd(4'h8, (i >> 1) & 1);
      end
      $display("edges done");
      // both pins at once: priority, auto clear, re-enable inside the routine
      ext_irq_pins <= 2'h2;
      repeat (3) @(posedge pclk);
      xfer(1'h1, 4'h6, 32'h9);
      xfer(1'h1, 4'h8, 32'h0);
      xfer(1'h1, 4'h7, 32'h7);
      ext_irq_pins <= 2'h1;
      wt(32'h0);
      chk(vec, {16'h0, VB});
      sav0 = sav;
      rd(4'h8, 32'h2);
      xfer(1'h1, 4'h7, 32'h7);
      wt(32'h1);
      rd(4'h9, 32'h2);
      pop(2'h1, sav);
      pop(2'h2, sav0);
      $display("pins done");
      // full stack holds off an enabled request until one pop
      xfer(1'h1, 4'h7, 32'h8);
      xfer(1'h1, 4'h0, 32'h1);
      repeat (8) begin
         call_req <= 1'h1;
         @(posedge pclk);
         sav = {16'h0, cpu_next_pc};
         call_req <= 1'h0;
         @(posedge pclk);
      end
      pulse;
      rd(4'h9, 32'h8);
      chk({31'h0, stack_full}, 32'h1);
      xfer(1'h1, 4'h7, 32'h9);
      wt(32'hFF);
      pop(2'h2, sav);
      wt(32'h2);
      presetn <= 1'h0;
      repeat (2) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      rd(4'h9, 32'h0);
      rd(4'h7, 32'h0);
      $display("stack done");
      close_out;
   end
endmodule
